/* File: logic/tdp_host_end.sv */
// adapter end of the two-wire debug port; makes the link clock
// assumes one request at a time from the user side
`timescale 1ns/1ps
module tdp_host_end #(
  parameter int unsigned HALF_CYC = tdp_pkg::LINK_HALF_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // link to the device
  tdp_link_if.host link,
  // request
  input wire logic req_valid,
  input wire tdp_pkg::tdp_op_e req_op,
  output logic req_ready,
  // answer
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic refused,
  output logic connected
);
  import tdp_pkg::*;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_FRAME = 2'b01,
    H_NEXT = 2'b11
  } tdp_hstate_e;

  typedef struct packed {
    logic clk_m;
    logic clk_s;
    logic dat_m;
    logic dat_s;
    tdp_hstate_e st;
    logic [7:0] div;
    logic [4:0] idx;
    logic [4:0] last;
    logic [7:0] cmd;
    logic [7:0] sh;
    logic [7:0] rx;
    logic pend;
    logic clk_o;
    logic clk_oe_n;
    logic dat_o;
    logic dat_oe_n;
    logic ready;
    logic rsp_v;
    logic refuse;
    logic conn;
  } tdp_host_s;

  localparam tdp_host_s HOST_RST = '{
    clk_m: 1'b1, clk_s: 1'b1, dat_m: 1'b1, dat_s: 1'b1,
    st: H_IDLE, div: 8'h00, idx: 5'h00, last: LAST_WR_IDX,
    cmd: SH_RST, sh: SH_RST, rx: SH_RST, pend: 1'b0,
    clk_o: 1'b1, clk_oe_n: 1'b1, dat_o: 1'b1, dat_oe_n: 1'b1,
    ready: 1'b0, rsp_v: 1'b0, refuse: 1'b0, conn: 1'b0
  };

  tdp_host_s r;
  tdp_host_s next_r;
  logic tick;
  logic [7:0] op_cmd;

  assign tick = (r.div == 8'(HALF_CYC - 1));

  always_comb begin
    case (req_op)
      OP_CONNECT: op_cmd = CMD_CONNECT;
      OP_DISCONNECT: op_cmd = CMD_BKPT_CLR;
      OP_RESET: op_cmd = CMD_RESET;
      OP_BKPT_SET: op_cmd = CMD_BKPT_SET;
      OP_BKPT_CLR: op_cmd = CMD_BKPT_CLR;
      default: op_cmd = CMD_STATUS;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // framer and clock divider

  always_comb begin
    next_r = r;
    next_r.clk_m = link.clk_pin;
    next_r.clk_s = r.clk_m;
    next_r.dat_m = link.dat_pin;
    next_r.dat_s = r.dat_m;
    next_r.rsp_v = 1'b0;
    next_r.refuse = 1'b0;
    next_r.div = tick ? 8'h00 : r.div + 8'h01;
    case (r.st)
      H_IDLE: begin
        if (req_valid && r.ready) begin
          // idle clock pin low means the led is lit: no connect
          if ((req_op == OP_CONNECT) ? (r.conn || !r.clk_s) :
              !r.conn) begin // R7
            next_r.refuse = 1'b1;
          end else begin
            next_r.st = H_FRAME;
            next_r.cmd = op_cmd;
            next_r.sh = op_cmd;
            // disconnect clears breakpoints first, then releases
            next_r.pend = (req_op == OP_DISCONNECT); // R9
            next_r.last = (req_op == OP_STATUS) ? LAST_RD_IDX : LAST_WR_IDX;
            next_r.idx = 5'h00;
            next_r.div = 8'h00;
            next_r.clk_o = 1'b0; // R1
            next_r.clk_oe_n = 1'b0;
            next_r.dat_o = 1'b0;
            next_r.dat_oe_n = 1'b0;
          end
        end
      end
      H_FRAME: begin
        if (tick) begin
          if (r.clk_o) begin
            next_r.clk_o = 1'b0;
            next_r.idx = r.idx + 5'h01;
            if (r.idx < LAST_WR_IDX) begin
              next_r.dat_o = r.sh[0];
              next_r.sh = {1'b0, r.sh[7:1]};
            end else begin
              // turn the wire round for the device
              next_r.dat_oe_n = 1'b1;
              next_r.dat_o = 1'b1;
            end
          end else if (r.idx > r.last) begin
            next_r.clk_oe_n = 1'b1;
            next_r.clk_o = 1'b1;
            next_r.dat_oe_n = 1'b1;
            next_r.st = r.pend ? H_NEXT : H_IDLE;
            if (r.cmd == CMD_CONNECT) begin
              next_r.conn = 1'b1; // R8
            end
            if (r.cmd == CMD_DISCONNECT) begin
              next_r.conn = 1'b0; // R9
            end
            next_r.rsp_v = (r.last == LAST_RD_IDX);
          end else begin
            next_r.clk_o = 1'b1;
            if (r.idx > LAST_WR_IDX) begin
              next_r.rx = {r.dat_s, r.rx[7:1]};
            end
          end
        end
      end
      H_NEXT: begin
        if (tick) begin
          next_r.st = H_FRAME;
          next_r.pend = 1'b0;
          next_r.cmd = CMD_DISCONNECT; // R9
          next_r.sh = CMD_DISCONNECT;
          next_r.last = LAST_WR_IDX;
          next_r.idx = 5'h00;
          next_r.clk_o = 1'b0;
          next_r.clk_oe_n = 1'b0;
          next_r.dat_o = 1'b0;
          next_r.dat_oe_n = 1'b0;
        end
      end
      default: begin
        next_r.st = H_IDLE;
      end
    endcase
    next_r.ready = (next_r.st == H_IDLE);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r <= HOST_RST;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs from the state register

  assign link.clk_host_o = r.clk_o;
  assign link.clk_host_oe_n = r.clk_oe_n;
  assign link.dat_host_o = r.dat_o;
  assign link.dat_host_oe_n = r.dat_oe_n;
  assign req_ready = r.ready;
  assign rsp_valid = r.rsp_v;
  assign rsp_data = r.rx;
  assign refused = r.refuse;
  assign connected = r.conn;

endmodule : tdp_host_end

/* File: logic/tdp_pkg.sv */
// constants shared by both ends of the two-wire debug port
// assumes one 25 MHz clock domain on each end
package tdp_pkg;

  // clock and link timing
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned LINK_HALF_NS = 320;
  localparam int unsigned LINK_HALF_CYC = LINK_HALF_NS / CLK_PERIOD_NS;

  // frame layout: start bit low, then a command byte lsb first
  localparam int unsigned FRAME_BITS = 8;
  localparam logic [4:0] LAST_WR_IDX = 5'h08;
  localparam logic [4:0] LAST_RD_IDX = 5'h10;

  // command codes carried on the data pin
  localparam logic [7:0] CMD_CONNECT = 8'ha5;
  localparam logic [7:0] CMD_DISCONNECT = 8'h5a;
  localparam logic [7:0] CMD_RESET = 8'hc3;
  localparam logic [7:0] CMD_BKPT_SET = 8'h11;
  localparam logic [7:0] CMD_BKPT_CLR = 8'h22;
  localparam logic [7:0] CMD_STATUS = 8'h3c;

  // status byte fields
  localparam int unsigned ST_SESSION = 0;
  localparam int unsigned ST_BKPT = 1;
  localparam int unsigned ST_LED = 2;
  localparam int unsigned ST_PART_LSB = 4;

  // reset values
  localparam logic [7:0] SH_RST = 8'h00;
  localparam logic [3:0] CNT_RST = 4'h0;

  typedef enum logic [1:0] {
    PART_FACTORY = 2'b00,
    PART_USER = 2'b01,
    PART_RUN = 2'b11
  } tdp_part_e;

  typedef enum logic [2:0] {
    OP_CONNECT = 3'h0,
    OP_DISCONNECT = 3'h1,
    OP_RESET = 3'h2,
    OP_BKPT_SET = 3'h3,
    OP_BKPT_CLR = 3'h4,
    OP_STATUS = 3'h5
  } tdp_op_e;

endpackage : tdp_pkg

/* File: logic/tdp_link_if.sv */
// two-wire link between debug adapter and device
// assumes pull-ups on both pins; the led sink shares the clock pin
`timescale 1ns/1ps
interface tdp_link_if;
  logic clk_host_o;
  logic clk_host_oe_n;
  logic led_sink;
  logic dat_host_o;
  logic dat_host_oe_n;
  logic dat_dev_o;
  logic dat_dev_oe_n;
  logic clk_pin;
  logic dat_pin;

  // led sink pulls the clock pin low, which is why connect needs it off
  assign clk_pin = led_sink ? 1'b0 :
    (!clk_host_oe_n ? clk_host_o : 1'b1);
  assign dat_pin = (!dat_host_oe_n ? dat_host_o : 1'b1) &
    (!dat_dev_oe_n ? dat_dev_o : 1'b1);

  modport dev (
    input clk_pin,
    input dat_pin,
    output led_sink,
    output dat_dev_o,
    output dat_dev_oe_n
  );

  modport host (
    input clk_pin,
    input dat_pin,
    output clk_host_o,
    output clk_host_oe_n,
    output dat_host_o,
    output dat_host_oe_n
  );
endinterface : tdp_link_if

/* File: logic/tdp_dev_end.sv */
// device end of the two-wire debug port with led pin sharing
// assumes the adapter keeps its side of the link; straps from own domain
//
// Operation
// R1 - one host clock, one shared data wire
// R2 - port can be disabled for good; code re-enables it once lock_fuse drops and part_state leaves PART_RUN
// R3 - debug traffic runs while core halted
// R4 - halted session hands pins to debug
// R5 - clock pin doubles as led sink
// R6 - led stays off during a session
// R7 - connect only while led is off
// R8 - host disables led from connect on
// R9 - host clears breakpoints and releases on exit
// R10 - after exit, led follows application again
// R11 - debug reset restarts digital logic, boot
// R12 - factory part keeps downloaded ram contents
// R13 - user part reloads ram from user region
// R14 - debug reset is only non-power reset
// R15 - finalized run part refuses all debug
// R16 - led gated by inverse of session flag
`timescale 1ns/1ps
module tdp_dev_end (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // link to the adapter
  tdp_link_if.dev link,
  // application side
  input wire logic led_request,
  input wire tdp_pkg::tdp_part_e part_state,
  input wire logic lock_fuse,
  // device control
  output logic led_sink_en,
  output logic core_halt,
  output logic pins_borrowed,
  output logic bkpt_armed,
  output logic session_active,
  output logic dig_reset,
  output logic boot_load_user
);
  import tdp_pkg::*;

  typedef enum logic [1:0] {
    D_IDLE = 2'b00,
    D_RECV = 2'b01,
    D_SEND = 2'b11
  } tdp_dstate_e;

  typedef struct packed {
    logic clk_m;
    logic clk_s;
    logic clk_q;
    logic dat_m;
    logic dat_s;
    tdp_dstate_e st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic dis;
    logic session;
    logic bkpt;
    logic led;
    logic dout;
    logic doe_n;
    logic drst;
    logic boot_user;
  } tdp_dev_s;

  localparam tdp_dev_s DEV_RST = '{
    clk_m: 1'b1, clk_s: 1'b1, clk_q: 1'b1,
    dat_m: 1'b1, dat_s: 1'b1,
    st: D_IDLE, cnt: CNT_RST, sh: SH_RST,
    dis: 1'b0, session: 1'b0, bkpt: 1'b0, led: 1'b0,
    dout: 1'b1, doe_n: 1'b1, drst: 1'b0, boot_user: 1'b0
  };

  tdp_dev_s r;
  tdp_dev_s next_r;
  logic rise;
  logic fall;
  logic [7:0] rx_byte;
  logic [7:0] status;

  ////////////////////////////////////////////////////////////////////////
  // edge finding on the synchronised pins

  // only the second and third stages feed edge logic
  assign rise = r.clk_s & ~r.clk_q;
  assign fall = ~r.clk_s & r.clk_q;
  assign rx_byte = {r.dat_s, r.sh[7:1]};

  always_comb begin
    status = 8'h00;
    status[ST_SESSION] = r.session;
    status[ST_BKPT] = r.bkpt;
    status[ST_LED] = r.led;
    status[ST_PART_LSB +: 2] = part_state;
  end

  ////////////////////////////////////////////////////////////////////////
  // protocol engine

  always_comb begin
    next_r = r;
    next_r.clk_m = link.clk_pin; // R1
    next_r.clk_s = r.clk_m;
    next_r.clk_q = r.clk_s;
    next_r.dat_m = link.dat_pin; // R1
    next_r.dat_s = r.dat_m;
    next_r.drst = 1'b0;
    // lock follows the straps; run parts lose the port
    next_r.dis = lock_fuse | (part_state == PART_RUN); // R2 R15
    if (r.dis) begin
      // silent: no reply, no session, pins left to the application
      next_r.st = D_IDLE; // R2 R15
      next_r.session = 1'b0;
      next_r.bkpt = 1'b0;
      next_r.doe_n = 1'b1;
      next_r.dout = 1'b1;
    end else begin
      case (r.st)
        D_IDLE: begin
          // start bit: data low at a clock rise
          if (rise && !r.dat_s) begin
            next_r.st = D_RECV;
            next_r.cnt = CNT_RST;
          end
        end
        D_RECV: begin
          if (rise) begin
            next_r.sh = rx_byte;
            next_r.cnt = r.cnt + 4'h1;
            if (r.cnt == 4'(FRAME_BITS - 1)) begin
              next_r.st = D_IDLE;
              if (rx_byte == CMD_CONNECT) begin
                // a lit led holds the clock low, so refuse anyway
                if (!r.led) begin // R7
                  next_r.session = 1'b1; // R8 R3
                end
              end else if (r.session) begin
                if (rx_byte == CMD_DISCONNECT) begin
                  next_r.session = 1'b0; // R9 R10
                  next_r.bkpt = 1'b0; // R9
                end else if (rx_byte == CMD_BKPT_SET) begin
                  next_r.bkpt = 1'b1;
                end else if (rx_byte == CMD_BKPT_CLR) begin
                  next_r.bkpt = 1'b0; // R9
                end else if (rx_byte == CMD_RESET) begin
                  // the only reset source short of power cycling
                  next_r.drst = 1'b1; // R11 R14
                  // factory parts keep the downloaded ram image
                  next_r.boot_user = (part_state == PART_USER); // R12 R13
                end else if (rx_byte == CMD_STATUS) begin
                  next_r.st = D_SEND;
                  next_r.sh = status;
                  next_r.cnt = CNT_RST;
                end
              end
            end
          end
        end
        D_SEND: begin
          // drive on the falling edge, host samples on the rise
          if (fall) begin
            if (r.cnt == 4'(FRAME_BITS)) begin
              next_r.doe_n = 1'b1;
              next_r.dout = 1'b1;
              next_r.st = D_IDLE;
            end else begin
              next_r.dout = r.sh[0]; // R1
              next_r.doe_n = 1'b0;
              next_r.sh = {1'b0, r.sh[7:1]};
              next_r.cnt = r.cnt + 4'h1;
            end
          end
        end
        default: begin
          next_r.st = D_IDLE;
        end
      endcase
    end
    // session flag masks the sink; app request returns on exit
    next_r.led = led_request & ~next_r.session; // R5 R6 R10 R16
  end

  ////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk) begin
    if (srst) begin
      r <= DEV_RST;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, all straight from the state register

  assign link.led_sink = r.led; // R5
  assign link.dat_dev_o = r.dout;
  assign link.dat_dev_oe_n = r.doe_n;
  assign led_sink_en = r.led; // R6
  assign core_halt = r.session; // R3
  assign pins_borrowed = r.session; // R4
  assign bkpt_armed = r.bkpt;
  assign session_active = r.session;
  assign dig_reset = r.drst; // R11
  assign boot_load_user = r.boot_user; // R13

endmodule : tdp_dev_end

/* File: tb/tdp_link_sva.sv */
// concurrent checks on the debug link wires and the device session outputs
// assumes one clock domain; placed beside the interface joining both ends
`timescale 1ns/1ps
module tdp_link_sva #(
  parameter int HALF_CYC = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // link wires
  input wire logic clk_host_o,
  input wire logic clk_host_oe_n,
  input wire logic led_sink,
  input wire logic dat_host_oe_n,
  input wire logic dat_dev_oe_n,
  // device side
  input wire logic led_request,
  input wire tdp_pkg::tdp_part_e part_state,
  input wire logic lock_fuse,
  input wire logic led_sink_en,
  input wire logic core_halt,
  input wire logic pins_borrowed,
  input wire logic session_active,
  input wire logic dig_reset,
  input wire logic boot_load_user
);
  import tdp_pkg::*;

  localparam int HC = HALF_CYC;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  ////////////////////////////////////////////////////////////////////////////
  // straps must settle through two stages before the port goes quiet
  sequence s_blocked;
    (lock_fuse || part_state == PART_RUN) [*3];
  endsequence
  sequence s_clk_rise;
    $rose(clk_host_o) && !clk_host_oe_n;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  AST_ONE_DRIVER: assert property (
    !dat_dev_oe_n |-> dat_host_oe_n) else $error("both ends drive data");
  AST_HALF_PERIOD: assert property (
    s_clk_rise |-> ##HC $fell(clk_host_o)) else $error("clock high phase");
  AST_RESET_IDLE: assert property (disable iff (1'b0)
    srst |=> dat_dev_oe_n && !led_sink && clk_host_oe_n && dat_host_oe_n &&
    !session_active) else $error("link not idle after reset");
  AST_LED_GATE: assert property (
    !$past(srst) |-> led_sink_en == ($past(led_request) && !session_active))
    else $error("led gating wrong");
  AST_HALT_PINS: assert property (
    core_halt == session_active && pins_borrowed == session_active &&
    (pins_borrowed || dat_dev_oe_n))
    else $error("halt or pin hand-over differs from session");
  AST_CONNECT_LED_OFF: assert property (
    $rose(session_active) |-> !$past(led_sink_en))
    else $error("session opened with led on");
  AST_LOCKED: assert property (
    s_blocked |-> !session_active && dat_dev_oe_n)
    else $error("locked port still active");
  AST_DBG_RESET_PULSE: assert property (
    dig_reset |-> session_active ##1 !dig_reset)
    else $error("debug reset pulse wrong");
  AST_BOOT_SRC: assert property (
    dig_reset |-> boot_load_user == ($past(part_state) == PART_USER))
    else $error("boot source wrong");
  AST_BOOT_HOLD: assert property (
    !dig_reset |-> $stable(boot_load_user))
    else $error("boot source moved without reset");
endmodule : tdp_link_sva

/* File: tb/testbench.sv */
// self-checking bench: host end and device end joined by the link
// assumes HALF_CYC 8; a flag model predicts every answer
`timescale 1ns/1ps
module testbench;
  import tdp_pkg::*;

  logic clk = 1'b0;
  logic srst = 1'b1;
  logic led_request = 1'b0;
  tdp_part_e part_state = PART_FACTORY;
  logic lock_fuse = 1'b0;
  logic req_valid = 1'b0;
  tdp_op_e req_op = OP_CONNECT;
  logic req_ready, rsp_valid, refused, connected;
  logic [7:0] rsp_data;
  logic led_sink_en, core_halt, pins_borrowed, bkpt_armed;
  logic session_active, dig_reset, boot_load_user;
  int n_fail = 0;
  int samples_checked = 0;
  int n_dr = 0;
  int m_dr = 0;
  bit [31:0] rs = 32'h0000000a;
  bit m_conn, m_sess, m_bkpt;
  logic wq[$];
  tdp_op_e seq_op [8] = '{OP_BKPT_SET, OP_STATUS, OP_RESET, OP_RESET,
    OP_BKPT_CLR, OP_BKPT_SET, OP_STATUS, OP_DISCONNECT};

  tdp_link_if link ();
  tdp_host_end #(.HALF_CYC(8)) tdp_host_end_i (.clk(clk), .srst(srst),
    .link(link), .req_valid(req_valid), .req_op(req_op),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .refused(refused), .connected(connected));
  tdp_dev_end tdp_dev_end_i (.clk(clk), .srst(srst), .link(link),
    .led_request(led_request), .part_state(part_state),
    .lock_fuse(lock_fuse), .led_sink_en(led_sink_en),
    .core_halt(core_halt), .pins_borrowed(pins_borrowed),
    .bkpt_armed(bkpt_armed), .session_active(session_active),
    .dig_reset(dig_reset), .boot_load_user(boot_load_user));
  tdp_link_sva #(.HALF_CYC(8)) tdp_link_sva_i (.clk(clk), .srst(srst),
    .clk_host_o(link.clk_host_o), .clk_host_oe_n(link.clk_host_oe_n),
    .led_sink(link.led_sink), .dat_host_oe_n(link.dat_host_oe_n),
    .dat_dev_oe_n(link.dat_dev_oe_n), .led_request(led_request),
    .part_state(part_state), .lock_fuse(lock_fuse),
    .led_sink_en(led_sink_en), .core_halt(core_halt),
    .pins_borrowed(pins_borrowed), .session_active(session_active),
    .dig_reset(dig_reset), .boot_load_user(boot_load_user));

  always #20 clk = ~clk;
  // counted on the falling edge, half a cycle after launch, so the pulse is seen settled
  always @(negedge clk) if (dig_reset === 1'b1) n_dr++;
  // wire-level capture of each bit the host clocks
  always @(posedge link.clk_pin) if (link.clk_host_oe_n === 1'b0)
    wq.push_back(link.dat_pin);

  ////////////////////////////////////////////////////////////////////////////
  function automatic bit [31:0] xs(bit [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs

  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out();
    $display("compares %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out

  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic do_reset();
    srst = 1'b1;
    cyc(5);
    srst = 1'b0;
    m_conn = 0;
    m_sess = 0;
    m_bkpt = 0;
    cyc(2);
    chk({session_active, bkpt_armed, connected, boot_load_user}, 8'h0);
    chk({link.clk_pin, link.dat_pin}, 8'h3);
  endtask : do_reset

  ////////////////////////////////////////////////////////////////////////////
  // one request, waited for under a bound, then compared with the model
  task automatic do_op(tdp_op_e op);
    logic [7:0] cmd, seen, got, want;
    bit ref_seen, exp_ref, blk;
    int i;
    blk = lock_fuse || part_state == PART_RUN;
    exp_ref = (op == OP_CONNECT) ? (m_conn || led_request) : !m_conn;
    case (op)
      OP_CONNECT: cmd = CMD_CONNECT;
      OP_RESET: cmd = CMD_RESET;
      OP_BKPT_SET: cmd = CMD_BKPT_SET;
      OP_STATUS: cmd = CMD_STATUS;
      default: cmd = CMD_BKPT_CLR;
    endcase
    wq.delete();
    ref_seen = 0;
    got = 8'hxx;
    req_op = op;
    req_valid = 1'b1;
    @(posedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    for (i = 0; i < 1200; i++) begin
      if (refused === 1'b1) ref_seen = 1;
      if (rsp_valid === 1'b1) got = rsp_data;
      if (i > 0 && req_ready === 1'b1) break;
      @(negedge clk);
    end
    // a request that never completes counts against the run
    chk(8'(i < 1200), 8'h1);
    cyc(2);
    chk(ref_seen, exp_ref);
    if (!exp_ref) begin
      while (wq.size() < 9) wq.push_back(1'bx);
      for (i = 0; i < 8; i++) seen[i] = wq[i + 1];
      chk({wq[0], seen == cmd}, 8'h1);
      case (op)
        OP_CONNECT: begin
          m_conn = 1;
          m_sess = !blk;
        end
        OP_DISCONNECT: begin
          m_conn = 0;
          m_sess = 0;
          m_bkpt = 0;
        end
        OP_RESET: if (m_sess) begin
          m_dr++;
          chk(boot_load_user, part_state == PART_USER);
        end
        OP_BKPT_SET: m_bkpt = m_bkpt | m_sess;
        OP_BKPT_CLR: m_bkpt = 0;
        default: begin
          want = blk ? 8'hff : {2'b00, part_state, 2'b00, m_bkpt, m_sess};
          chk(got, want);
        end
      endcase
    end
    seen = {5'h00, session_active, bkpt_armed, connected};
    chk(seen, {m_sess, m_bkpt, m_conn});
    chk(8'(n_dr), 8'(m_dr));
  endtask : do_op

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset();
    do_op(OP_STATUS);
    led_request = 1'b1;
    cyc(3);
    chk({led_sink_en, link.clk_pin}, 8'h2);
    do_op(OP_CONNECT);
    led_request = 1'b0;
    cyc(3);
    do_op(OP_CONNECT);
    chk({core_halt, pins_borrowed}, 8'h3);
    do_op(OP_CONNECT);
    for (int k = 0; k < 8; k++) begin
      rs = xs(rs);
      // status reads keep the led quiet so its field is predictable
      led_request = (seq_op[k] != OP_STATUS) ? rs[0] : 1'b0;
      part_state = (k >= 3) ? PART_USER : PART_FACTORY;
      do_op(seq_op[k]);
      if (k < 7) chk(led_sink_en, 1'b0);
    end
    led_request = 1'b1;
    cyc(3);
    chk(led_sink_en, 1'b1);
    led_request = 1'b0;
    cyc(3);
    for (int j = 0; j < 2; j++) begin
      lock_fuse = (j == 0);
      part_state = j ? PART_RUN : PART_FACTORY;
      cyc(3);
      do_op(OP_CONNECT);
      do_op(OP_STATUS);
      do_op(OP_DISCONNECT);
    end
    lock_fuse = 1'b0;
    part_state = PART_FACTORY;
    do_op(OP_CONNECT);
    do_reset();
    do_op(OP_CONNECT);
    do_op(OP_DISCONNECT);
    close_out();
  end

  // hang guard, about two and a half times the expected run
  initial begin
    #400000;
    n_fail++;
    close_out();
  end
endmodule : testbench
